//--- src/edge_timer_pkg.sv
/*
 * Shared constants and types for the edge measurement timer channel:
 * register offsets, control field layout, reset values, counter steps.
 * Assumes a 32-bit APB with byte addresses and one word per register.
 */
`default_nettype none

package edge_timer_pkg;

    // ********************************
    // register map (byte offsets)
    // ********************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_TIME = 8'h0C;
    localparam logic [7:0] OFF_EVENT = 8'h10;
    localparam logic [7:0] OFF_AUX = 8'h14;
    localparam logic [7:0] OFF_GRA = 8'h18;
    localparam logic [7:0] OFF_GRB = 8'h1C;
    localparam logic [7:0] OFF_GRC = 8'h20;
    localparam logic [7:0] OFF_GRD = 8'h24;

    // ********************************
    // control fields and modes
    // ********************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SEL_LSB = 2;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_ROT = 2'h1;
    localparam logic [1:0] MODE_UPDN = 2'h2;
    localparam logic [1:0] MODE_QUAD = 2'h3;
    localparam int CLK_LINES = 6;

    // ********************************
    // status bit positions
    // ********************************
    localparam int ST_CAP = 0;
    localparam int ST_TOVF = 1;
    localparam int ST_EOVF = 2;
    localparam int ST_AOVF = 3;

    // ********************************
    // counter steps and reset values
    // ********************************
    localparam logic [31:0] TC_STEP = 32'h0000_0100;
    localparam logic [31:0] TC_CLR_CNT = 32'h0000_0100;
    localparam logic [31:0] TC_ZERO = 32'h0000_0000;
    localparam logic [31:0] TC_TOP = 32'hFFFF_FF00;
    localparam logic [15:0] EC_TOP = 16'hFFFF;
    localparam logic [15:0] EC_ZERO = 16'h0000;
    localparam logic [31:0] GR_RST = 32'h0000_0000;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    typedef struct packed {
        logic aovf;
        logic eovf;
        logic tovf;
        logic cap;
    } flags_t;

endpackage

`default_nettype wire

//--- src/edge_timer.sv
/*
 * One channel of an edge measurement timer with APB register access:
 * rotation/pulse measurement, up/down and quadrature event counting,
 * overflow and underflow flags, one masked level interrupt.
 * Assumes clk_bus lines are one-cycle enables made on pclk by a shared
 * prescaler, and pulse inputs are asynchronous pins.
 */
// How it works
// - rotation: time counter counts while input A low
// - rotation: edge clears time counter, 0x100 if low
// - rotation: event counter counts synchronized rising edges
// - rotation: register A captures time counter on edge
// - aux counter shares clock, clears to 0x100
// - rotation: register C captures aux counter on edge
// - rotation: register D accumulates aux before clearing
// - rotation: aux counter matching register B low byte flags
// - rotation: capture flag set on next count clock
// - counting modes: time counter clears after A match
// - up/down: both A edges, B high counts down
// - counting modes: register B captures event counter
// - counting modes: capture flag after compare match
// - quadrature: all edges except coincident A and B edges, direction from other input
// - wrap to zero without clear sets overflow
// - event counter underflow sets its overflow flag
`default_nettype none

module edge_timer
    import edge_timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CLK_LINES-1:0] clk_bus,
    input wire logic pulse_input_a,
    input wire logic pulse_input_b,
    output logic irq
);

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic a_meta;
        logic a_sync;
        logic a_prev;
        logic b_meta;
        logic b_sync;
        logic b_prev;
        logic edge_pend;
        logic cmp_hit;
        logic [1:0] mode;
        logic [2:0] clk_sel;
        flags_t status;
        flags_t mask;
        logic [31:0] time_counter;
        logic [15:0] event_counter;
        logic [31:0] aux_time_counter;
        logic [31:0] general_reg_a;
        logic [31:0] general_reg_b;
        logic [31:0] general_reg_c;
        logic [31:0] general_reg_d;
        logic [31:0] prdata;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic tick;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic ec_up;
    logic ec_dn;
    logic aux_match;
    logic counting;
    logic wr;
    logic rd_setup;
    logic mapped;
    flags_t set;
    flags_t clr;

    // ********************************
    // combinational helpers
    // ********************************
    // selects 6 and 7 give no count clock at all
    assign tick = (s_r.clk_sel < 3'(CLK_LINES)) && (s_r.mode != MODE_OFF)
                  && clk_bus[s_r.clk_sel];
    assign a_rise = s_r.a_sync && !s_r.a_prev;
    assign a_fall = !s_r.a_sync && s_r.a_prev;
    assign b_rise = s_r.b_sync && !s_r.b_prev;
    assign b_fall = !s_r.b_sync && s_r.b_prev;
    assign counting = (s_r.mode == MODE_UPDN) || (s_r.mode == MODE_QUAD);
    // compared in count units: bits above the 0x100 step
    assign aux_match = (s_r.mode == MODE_ROT)
                       && (s_r.aux_time_counter[31:8]
                           == {16'h0000, s_r.general_reg_b[7:0]});

    always_comb begin
        ec_up = 1'b0;
        ec_dn = 1'b0;
        unique case (s_r.mode)
            MODE_ROT: begin
                ec_up = a_rise;
            end
            MODE_UPDN: begin
                ec_up = (a_rise || a_fall) && !s_r.b_sync;
                ec_dn = (a_rise || a_fall) && s_r.b_sync;
            end
            MODE_QUAD: begin
                // coincident edges on both inputs are dropped
                if (!((a_rise || a_fall) && (b_rise || b_fall))) begin
                    ec_up = (a_rise && !s_r.b_sync) || (a_fall && s_r.b_sync)
                         || (b_rise && s_r.a_sync) || (b_fall && !s_r.a_sync);
                    ec_dn = (a_rise && s_r.b_sync) || (a_fall && !s_r.b_sync)
                         || (b_rise && !s_r.a_sync) || (b_fall && s_r.a_sync);
                end
            end
            default: begin
            end
        endcase
    end

    // ********************************
    // apb slave
    // ********************************
    // zero wait: read data is loaded in the setup cycle
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign prdata = s_r.prdata;

    always_comb begin
        unique case (paddr)
            OFF_CTRL, OFF_STATUS, OFF_MASK, OFF_TIME, OFF_EVENT, OFF_AUX,
            OFF_GRA, OFF_GRB, OFF_GRC, OFF_GRD: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    assign irq = |(s_r.status & s_r.mask);

    // ********************************
    // next state
    // ********************************
    always_comb begin
        s_nxt = s_r;
        set = '0;
        clr = '0;

        // three flops per pin; the first one never feeds logic
        s_nxt.a_meta = pulse_input_a;
        s_nxt.a_sync = s_r.a_meta;
        s_nxt.a_prev = s_r.a_sync;
        s_nxt.b_meta = pulse_input_b;
        s_nxt.b_sync = s_r.b_meta;
        s_nxt.b_prev = s_r.b_sync;

        // one pending edge only: faster edges merge into one capture
        s_nxt.edge_pend = (s_r.edge_pend && !tick)
                          || ((s_r.mode == MODE_ROT) && (a_rise || a_fall));

        // event counter with wrap detection
        if (ec_up) begin
            s_nxt.event_counter = s_r.event_counter + 16'h0001;
            set.eovf = (s_r.event_counter == EC_TOP);
        end else if (ec_dn) begin
            s_nxt.event_counter = s_r.event_counter - 16'h0001;
            set.eovf = (s_r.event_counter == EC_ZERO);
        end

        if (s_r.mode == MODE_ROT) begin
            if (tick && s_r.edge_pend) begin
                s_nxt.time_counter = s_r.a_sync ? TC_ZERO : TC_CLR_CNT;
                s_nxt.aux_time_counter = TC_CLR_CNT;
                s_nxt.general_reg_a = s_r.time_counter;
                s_nxt.general_reg_c = s_r.aux_time_counter;
                s_nxt.general_reg_d = s_r.general_reg_d
                                      + s_r.aux_time_counter;
                set.cap = 1'b1;
            end else if (tick) begin
                if (!s_r.a_sync) begin
                    s_nxt.time_counter = s_r.time_counter + TC_STEP;
                    set.tovf = (s_r.time_counter == TC_TOP);
                end
                s_nxt.aux_time_counter = s_r.aux_time_counter + TC_STEP;
                set.aovf = (s_r.aux_time_counter == TC_TOP);
            end
            set.aovf = set.aovf || aux_match;
        end

        if (counting) begin
            s_nxt.cmp_hit = (s_r.time_counter == s_r.general_reg_a)
                            && !s_r.cmp_hit;
            if (s_r.cmp_hit) begin
                // a count landing on the clear keeps its step
                s_nxt.time_counter = tick ? TC_CLR_CNT : TC_ZERO;
                s_nxt.general_reg_b = {16'h0000, s_r.event_counter};
                set.cap = 1'b1;
            end else if (tick) begin
                s_nxt.time_counter = s_r.time_counter + TC_STEP;
                set.tovf = (s_r.time_counter == TC_TOP);
            end
        end else begin
            s_nxt.cmp_hit = 1'b0;
        end

        // software access; hardware captures take precedence
        if (wr) begin
            unique case (paddr)
                OFF_CTRL: begin
                    s_nxt.mode = pwdata[CTRL_MODE_LSB +: 2];
                    s_nxt.clk_sel = pwdata[CTRL_SEL_LSB +: 3];
                end
                OFF_STATUS: clr = flags_t'(pwdata[3:0]);
                OFF_MASK: s_nxt.mask = flags_t'(pwdata[3:0]);
                OFF_GRA: begin
                    if (!(s_r.mode == MODE_ROT && tick && s_r.edge_pend)) begin
                        s_nxt.general_reg_a = pwdata;
                    end
                end
                OFF_GRB: begin
                    if (!(counting && s_r.cmp_hit)) begin
                        s_nxt.general_reg_b = pwdata;
                    end
                end
                OFF_GRD: begin
                    if (!(s_r.mode == MODE_ROT && tick && s_r.edge_pend)) begin
                        s_nxt.general_reg_d = pwdata;
                    end
                end
                default: begin
                end
            endcase
        end

        // a set in the same cycle as its clear survives
        s_nxt.status = (s_r.status & ~clr) | set;

        if (rd_setup) begin
            unique case (paddr)
                OFF_CTRL: s_nxt.prdata = {27'h0, s_r.clk_sel, s_r.mode};
                OFF_STATUS: s_nxt.prdata = {28'h0, s_r.status};
                OFF_MASK: s_nxt.prdata = {28'h0, s_r.mask};
                OFF_TIME: s_nxt.prdata = s_r.time_counter;
                OFF_EVENT: s_nxt.prdata = {16'h0000, s_r.event_counter};
                OFF_AUX: s_nxt.prdata = s_r.aux_time_counter;
                OFF_GRA: s_nxt.prdata = s_r.general_reg_a;
                OFF_GRB: s_nxt.prdata = s_r.general_reg_b;
                OFF_GRC: s_nxt.prdata = s_r.general_reg_c;
                OFF_GRD: s_nxt.prdata = s_r.general_reg_d;
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************************
    // assertions
    // ********************************
    // all checks run on pclk and pause while reset is low
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_low_count_only: assert property (
        (s_r.mode == MODE_ROT) && tick && !s_r.edge_pend && s_r.a_sync
        |=> s_r.time_counter == $past(s_r.time_counter))
        else $error("time counter moved while input A high");

    a_rot_clear_value: assert property (
        (s_r.mode == MODE_ROT) && tick && s_r.edge_pend && !s_r.a_sync
        |=> (s_r.time_counter == TC_CLR_CNT)
            && (s_r.aux_time_counter == TC_CLR_CNT))
        else $error("rotation clear value wrong");

    a_rot_event_inc: assert property (
        (s_r.mode == MODE_ROT) ##0 $rose(s_r.a_sync)
        |=> s_r.event_counter == $past(s_r.event_counter) + 16'h0001)
        else $error("rising edge not counted");

    a_rot_captures: assert property (
        (s_r.mode == MODE_ROT) && tick && s_r.edge_pend
        |=> (s_r.general_reg_a == $past(s_r.time_counter))
            && (s_r.general_reg_c == $past(s_r.aux_time_counter))
            && s_r.status.cap)
        else $error("rotation capture missing");

    a_stamp_accum: assert property (
        (s_r.mode == MODE_ROT) && tick && s_r.edge_pend
        |=> s_r.general_reg_d == $past(s_r.general_reg_d)
            + $past(s_r.aux_time_counter))
        else $error("time stamp not accumulated");

    a_aux_limit_flag: assert property (
        aux_match |=> s_r.status.aovf)
        else $error("aux limit flag not set");

    a_period_clear: assert property (
        counting && (s_r.time_counter == s_r.general_reg_a) && !s_r.cmp_hit
        ##1 counting
        |=> s_r.time_counter <= TC_CLR_CNT)
        else $error("time counter not cleared after match");

    a_period_capture: assert property (
        counting && s_r.cmp_hit
        |=> (s_r.general_reg_b[15:0] == $past(s_r.event_counter))
            && s_r.status.cap)
        else $error("event count not captured");

    a_event_wrap: assert property (
        ec_up && (s_r.event_counter == EC_TOP)
        |=> (s_r.event_counter == EC_ZERO) && s_r.status.eovf)
        else $error("event overflow missed");

    a_event_under: assert property (
        ec_dn && (s_r.event_counter == EC_ZERO)
        |=> (s_r.event_counter == EC_TOP) && s_r.status.eovf)
        else $error("event underflow missed");

    a_updn_dir: assert property (
        (s_r.mode == MODE_UPDN) && (a_rise || a_fall)
        |=> s_r.event_counter == ($past(s_r.b_sync)
            ? $past(s_r.event_counter) - 16'h0001
            : $past(s_r.event_counter) + 16'h0001))
        else $error("up/down direction wrong");

    a_quad_a_step: assert property (
        (s_r.mode == MODE_QUAD) && (a_rise || a_fall) && !(b_rise || b_fall)
        |=> s_r.event_counter
            == (($past(s_r.a_sync) == $past(s_r.b_sync))
                ? $past(s_r.event_counter) - 16'h0001
                : $past(s_r.event_counter) + 16'h0001))
        else $error("quadrature A edge counted wrong");

    a_quad_b_step: assert property (
        (s_r.mode == MODE_QUAD) && (b_rise || b_fall) && !(a_rise || a_fall)
        |=> s_r.event_counter
            == (($past(s_r.a_sync) == $past(s_r.b_sync))
                ? $past(s_r.event_counter) + 16'h0001
                : $past(s_r.event_counter) - 16'h0001))
        else $error("quadrature B edge counted wrong");

    c_rot_capture: cover property (
        (s_r.mode == MODE_ROT) && tick && s_r.edge_pend);
    c_period_match: cover property (counting && s_r.cmp_hit);
    c_quad_down: cover property ((s_r.mode == MODE_QUAD) && ec_dn);
    c_irq_aux: cover property (irq && s_r.status.aovf);
    c_event_under: cover property (ec_dn && (s_r.event_counter == EC_ZERO));

endmodule

`default_nettype wire

//--- dv/pulse_source.sv
/*
 * Model of the encoder or sensor that drives the two pulse inputs.
 * Assumes one bench process calls its tasks, right after a pclk edge.
 */
`default_nettype none

module pulse_source (
    input wire logic pclk,
    output logic pulse_input_a,
    output logic pulse_input_b
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************
    // edge drivers
    // ********************************
    initial begin
        pulse_input_a = 1'b0;
        pulse_input_b = 1'b0;
    end

    // 4-cycle gap: above one tick and above 1.5 pclk between phases
    task automatic set_a(input logic v);
        @(posedge pclk);
        pulse_input_a <= v;
        repeat (4) @(posedge pclk);
    endtask

    task automatic set_b(input logic v);
        @(posedge pclk);
        pulse_input_b <= v;
        repeat (4) @(posedge pclk);
    endtask
endmodule

`default_nettype wire

//--- dv/edge_timer_measure_count_test.sv
/*
 * Self-checking bench for the edge timer channel: APB master tasks,
 * one task per scenario, pulse source model on the pins.
 * Assumes count-clock line 0 ticks every pclk, so sel stays 0 outside t_clk_sel.
 */
`default_nettype none

module edge_timer_measure_count_test import edge_timer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [CLK_LINES-1:0] clk_bus;
    logic pulse_input_a, pulse_input_b;
    int tick_cnt, cycles, num_errors, n_tests;

    edge_timer dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .clk_bus(clk_bus),
        .pulse_input_a(pulse_input_a),
        .pulse_input_b(pulse_input_b),
        .irq(irq)
    );
    pulse_source enc (
        .pclk(pclk),
        .pulse_input_a(pulse_input_a),
        .pulse_input_b(pulse_input_b)
    );

    // ********************************
    // clock, count clocks, timeout
    // ********************************
    always #10 pclk = ~pclk;

    // line k ticks every k+1 cycles, like a shared prescaler
    always @(posedge pclk) begin
        tick_cnt <= tick_cnt + 1;
        for (int k = 0; k < CLK_LINES; k++) begin
            clk_bus[k] <= (tick_cnt % (k + 1)) == 0;
        end
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            num_errors = num_errors + 1;
            close_out();
        end
    end

    // ********************************
    // shared tasks
    // ********************************
    task automatic close_out();
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
        input string what);
        logic [31:0] q;
        rd(a, q);
        check(q, exp, what);
    endtask

    task automatic flag(input int bit_no, input logic exp, input string w);
        logic [31:0] q;
        rd(OFF_STATUS, q);
        check(32'(q[bit_no]), 32'(exp), w);
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rdc(OFF_CTRL, 32'h0, "ctrl reset");
        rdc(OFF_STATUS, 32'h0, "status reset");
        rdc(OFF_MASK, 32'h0, "mask reset");
        rdc(OFF_TIME, 32'h0, "time reset");
        rdc(OFF_GRD, 32'h0, "grd reset");
        check(32'(irq), 32'h0, "irq reset");
        check(32'(pready), 32'h1, "pready zero wait");
        apb(1'b0, 8'h40, 32'h0, q, e);
        check({q[30:0], e}, 32'h1, "unmapped read");
        wr(OFF_GRC, 32'hFFFF_FF00);
        rdc(OFF_GRC, 32'h0, "grc read only");
    endtask

    task automatic t_aux_limit();
        wr(OFF_GRB, 32'hFFFF_FF03);
        wr(OFF_MASK, 32'h0000_0008);
        wr(OFF_CTRL, 32'(MODE_ROT));
        repeat (12) @(posedge pclk);
        flag(ST_AOVF, 1'b1, "aux limit flag");
        check(32'(irq), 32'h1, "irq on aux flag");
        wr(OFF_STATUS, 32'h0000_0008);
        flag(ST_AOVF, 1'b0, "aux flag cleared");
        check(32'(irq), 32'h0, "irq after clear");
    endtask

    task automatic t_rotation();
        logic [31:0] q, c1, c2;
        wr(OFF_STATUS, 32'h0000_000F);
        wr(OFF_MASK, 32'h0000_0001);
        enc.set_a(1'b1);
        repeat (4) @(posedge pclk);
        rdc(OFF_EVENT, 32'h1, "rising edge counted");
        flag(ST_CAP, 1'b1, "capture flag");
        check(32'(irq), 32'h1, "irq on capture");
        rdc(OFF_TIME, 32'h0, "time cleared, input high");
        rd(OFF_GRA, q);
        check(32'(q != 0 && q[7:0] == 8'h0), 32'h1, "gra capture");
        rd(OFF_GRC, c1);
        rdc(OFF_GRD, c1, "grd first sum");
        repeat (6) @(posedge pclk);
        rdc(OFF_TIME, 32'h0, "time held while high");
        wr(OFF_STATUS, 32'h0000_000F);
        enc.set_a(1'b0);
        repeat (4) @(posedge pclk);
        rdc(OFF_EVENT, 32'h1, "falling edge not counted");
        rd(OFF_TIME, q);
        check(32'(q != 0 && q[7:0] == 8'h0), 32'h1, "time counts low");
        rd(OFF_GRC, c2);
        check(32'(c2 > c1), 32'h1, "grc cycle time");
        rdc(OFF_GRD, c1 + c2, "grd accumulates");
        flag(ST_CAP, 1'b1, "capture on fall");
    endtask

    task automatic t_updown();
        logic [31:0] q;
        int n;
        // period above where the time counter stands when the mode switches,
        // so the first match comes without waiting for a wrap
        wr(OFF_CTRL, 32'(MODE_UPDN));
        wr(OFF_GRA, 32'h0000_4000);
        wr(OFF_STATUS, 32'h0000_000F);
        enc.set_b(1'b1);
        enc.set_a(1'b1);
        rdc(OFF_EVENT, 32'h0, "count down on rise");
        flag(ST_EOVF, 1'b0, "no flag at zero");
        enc.set_a(1'b0);
        rdc(OFF_EVENT, 32'h0000_FFFF, "underflow value");
        flag(ST_EOVF, 1'b1, "underflow flag");
        wr(OFF_STATUS, 32'h0000_000F);
        enc.set_b(1'b0);
        enc.set_a(1'b1);
        flag(ST_EOVF, 1'b1, "event wrap flag");
        enc.set_a(1'b0);
        rdc(OFF_EVENT, 32'h1, "count up on fall");
        wr(OFF_STATUS, 32'h0000_000F);
        n = 0;
        do begin
            rd(OFF_STATUS, q);
            n++;
        end while (q[ST_CAP] !== 1'b1 && n < 40);
        check(32'(q[ST_CAP]), 32'h1, "period capture flag");
        rdc(OFF_GRB, 32'h1, "grb holds count");
        rd(OFF_TIME, q);
        check(32'(q <= 32'h0000_4000), 32'h1, "period clear");
    endtask

    // line 5 ticks once in 6 cycles: 12 cycles between the two reads
    task automatic t_clk_sel();
        logic [31:0] q1, q2;
        wr(OFF_GRA, 32'hFFFF_FF00);
        wr(OFF_CTRL, 32'(MODE_UPDN) | (32'h0000_0005 << CTRL_SEL_LSB));
        rd(OFF_TIME, q1);
        repeat (9) @(posedge pclk);
        rd(OFF_TIME, q2);
        check(q2 - q1, 32'h0000_0200, "line 5 count rate");
        wr(OFF_CTRL, 32'(MODE_UPDN) | (32'h0000_0006 << CTRL_SEL_LSB));
        rd(OFF_TIME, q1);
        repeat (9) @(posedge pclk);
        rdc(OFF_TIME, q1, "select 6 gives no count");
    endtask

    task automatic t_quad();
        wr(OFF_CTRL, 32'(MODE_QUAD));
        enc.set_a(1'b1);
        enc.set_b(1'b1);
        enc.set_a(1'b0);
        enc.set_b(1'b0);
        rdc(OFF_EVENT, 32'h5, "four steps forward");
        enc.set_b(1'b1);
        enc.set_a(1'b1);
        rdc(OFF_EVENT, 32'h3, "two steps back");
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        clk_bus = '0;
        tick_cnt = 0;
        cycles = 0;
        num_errors = 0;
        n_tests = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_aux_limit();
        t_rotation();
        t_updown();
        t_quad();
        t_clk_sel();
        close_out();
    end
endmodule

`default_nettype wire
